// ### hw/timer_channel_pair_mode_control.sv
// mode control, input filters and capture dividers for timer channels 0 and 1
// Functional notes
// R01: preload routes compare writes to shadow, update copies
// R02: software enables preload for pwm except one-shot
// R03: channel 0 direction writable only while channel idle
// R04: direction 00 output, 01 own pin, 10 pair
// R05: direction 11 uses trigger line, internal source only
// R06: filter samples input continuously, counts equal samples
// R07: new level valid at threshold; code zero bypasses
// R08: filter codes set sample count and sample rate
// R09: capture divider counter cleared while channel disabled
// R10: capture every 1, 2, 4 or 8 edges
// R11: channel 1 fields mirror channel 0 behaviour
// R12: software keeps reserved bits at reset value
// R13: software accesses control word as full word
// R14: differing sample restarts count, last level held
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module timer_channel_pair_mode_control
   import timer_pair_pkg::*;
(
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   input  wire logic        ch0_pin_in,
   input  wire logic        ch1_pin_in,
   input  wire logic        internal_trigger_line_in,
   input  wire logic [2:0]  trigger_source_select_in,
   input  wire logic        ch0_active_enable_in,
   input  wire logic        ch1_active_enable_in,
   input  wire logic        update_event_in,
   output logic             ch0_capture_out,
   output logic             ch1_capture_out,
   output logic      [1:0]  filtered_level_out,
   output logic      [31:0] ch0_compare_value_out,
   output logic             ch0_cmp_preload_enable_out
);

   logic [31:0] ctrl_reg;
   logic [31:0] cmp_shadow_reg;
   logic [31:0] cmp_active_reg;
   logic [31:0] rdata_reg;
   logic [31:0] status_word;
   logic [1:0]  pin_meta_reg;
   logic [1:0]  pin_sync_reg;
   logic [3:0]  dts_cnt_reg;
   logic        dts_tick;
   logic [4:0]  div_cnt_reg;
   logic [3:0]  filt_code [2];
   logic [3:0]  filt_thr  [2];
   logic [1:0]  strobe;
   logic [3:0]  eq_cnt_reg [2];
   logic [3:0]  eq_cnt_next [2];
   logic [1:0]  prev_samp_reg;
   logic [1:0]  level_reg;
   dir_t        dir [2];
   logic [1:0]  psc [2];
   logic [1:0]  chan_en;
   logic        trig_internal;
   logic [1:0]  src;
   logic [1:0]  src_prev_reg;
   logic [1:0]  edge_seen;
   logic [2:0]  edge_cnt_reg [2];
   logic [1:0]  capture_reg;
   logic        preload_on;
   logic        ctrl_wr;
   logic        cmp_wr;

   // strobe for one filter: every kernel cycle or every 2**k dts ticks
   function automatic logic rate_strobe(input logic [2:0] k,
                                        input logic       tick,
                                        input logic [4:0] cnt);
      logic [4:0] mask;
      mask = 5'((6'h01 << k) - 6'h01);
      if (k == 3'h0) begin
         return 1'b1;
      end
      return tick && ((cnt & mask) == mask);
   endfunction

   // edges needed per capture, less one
   function automatic logic [2:0] psc_last(input logic [1:0] p);
      return 3'((4'h1 << p) - 4'h1);
   endfunction

   // field decode from the control word
   assign dir[0]       = dir_t'(ctrl_reg[CH0_MS_POS +: 2]);
   assign dir[1]       = dir_t'(ctrl_reg[CH1_MS_POS +: 2]);
   assign psc[0]       = ctrl_reg[CH0_PSC_POS +: 2];
   assign psc[1]       = ctrl_reg[CH1_PSC_POS +: 2];
   assign filt_code[0] = ctrl_reg[CH0_FILT_POS +: 4];
   assign filt_code[1] = ctrl_reg[CH1_FILT_POS +: 4]; // [R11]
   assign chan_en      = {ch1_active_enable_in, ch0_active_enable_in};
   assign ctrl_wr      = wr_in && (addr_in == CTRL_OFFSET); // [R13]
   assign cmp_wr       = wr_in && (addr_in == CMP_OFFSET);

   // preload bit only means preload while channel 0 is an output
   assign preload_on = ctrl_reg[CH0_PRELOAD_POS] && (dir[0] == DIR_OUTPUT);

   // control word; direction fields locked while their channel runs
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ctrl_reg <= CTRL_RESET;
      end else if (ctrl_wr) begin
         // upper half kept at zero, write data for the reserved bits is ignored
         ctrl_reg[31:CTRL_USED_W] <= CTRL_RESET[31:CTRL_USED_W]; // [R12]
         ctrl_reg[7:2]   <= wdata_in[7:2];
         ctrl_reg[15:10] <= wdata_in[15:10];
         if (!ch0_active_enable_in) begin
            ctrl_reg[CH0_MS_POS +: 2] <= wdata_in[CH0_MS_POS +: 2]; // [R03]
         end
         if (!ch1_active_enable_in) begin
            ctrl_reg[CH1_MS_POS +: 2] <= wdata_in[CH1_MS_POS +: 2]; // [R11]
         end
      end
   end

   // compare value: shadow always written, active follows on update under preload, on write otherwise
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         cmp_shadow_reg <= CMP_RESET;
         cmp_active_reg <= CMP_RESET;
      end else begin
         if (cmp_wr) begin
            cmp_shadow_reg <= wdata_in;
         end
         if (preload_on) begin
            if (update_event_in) begin
               cmp_active_reg <= cmp_shadow_reg; // [R01]
            end
         end else if (cmp_wr) begin
            cmp_active_reg <= wdata_in;
         end
      end
   end

   // pins come from outside the clock domain, two flops first
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         pin_meta_reg <= 2'h0;
         pin_sync_reg <= 2'h0;
      end else begin
         pin_meta_reg <= {ch1_pin_in, ch0_pin_in};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // dead-time clock as a tick, then a free divider for the slow rates
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         dts_cnt_reg <= 4'h0;
         div_cnt_reg <= 5'h00;
      end else begin
         if (dts_tick) begin
            dts_cnt_reg <= 4'h0;
            div_cnt_reg <= div_cnt_reg + 5'h01;
         end else begin
            dts_cnt_reg <= dts_cnt_reg + 4'h1;
         end
      end
   end
   assign dts_tick = (dts_cnt_reg == DTS_DIV_CYCLES - 4'h1);

   // per channel sample strobe and threshold
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         filt_thr[i] = filt_times(filt_code[i]); // [R08]
         strobe[i]   = rate_strobe(filt_rate(filt_code[i]), dts_tick,
                                   div_cnt_reg); // [R08]
      end
   end

   // run length including the sample now taken, saturating at threshold
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (pin_sync_reg[i] != prev_samp_reg[i]) begin
            eq_cnt_next[i] = 4'h1; // [R14]
         end else if (eq_cnt_reg[i] < filt_thr[i]) begin
            eq_cnt_next[i] = eq_cnt_reg[i] + 4'h1; // [R06]
         end else begin
            eq_cnt_next[i] = eq_cnt_reg[i];
         end
      end
   end

   // digital filters; a glitch shorter than the threshold never shows
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         for (int i = 0; i < 2; i++) begin
            eq_cnt_reg[i] <= 4'h0;
         end
         prev_samp_reg <= 2'h0;
         level_reg     <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (filt_code[i] == 4'h0) begin
               level_reg[i]     <= pin_sync_reg[i]; // [R07]
               prev_samp_reg[i] <= pin_sync_reg[i];
               eq_cnt_reg[i]    <= 4'h0;
            end else if (strobe[i]) begin
               prev_samp_reg[i] <= pin_sync_reg[i]; // [R06]
               eq_cnt_reg[i]    <= eq_cnt_next[i];
               if (eq_cnt_next[i] >= filt_thr[i]) begin
                  level_reg[i] <= pin_sync_reg[i]; // [R07]
               end
            end
         end
      end
   end

   // capture source per channel; trigger line gated by source choice
   assign trig_internal = (trigger_source_select_in <= TRIG_INTERNAL_LAST);
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         unique case (dir[i])
            DIR_OUTPUT:  src[i] = 1'b0; // [R04]
            DIR_IN_OWN:  src[i] = level_reg[i]; // [R04]
            DIR_IN_PAIR: src[i] = level_reg[1 - i]; // [R04]
            DIR_IN_TRIG: src[i] = internal_trigger_line_in && trig_internal;
         endcase // [R05]
      end
   end

   // rising edges of the chosen source
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         src_prev_reg <= 2'h0;
      end else begin
         src_prev_reg <= src;
      end
   end
   assign edge_seen = src & ~src_prev_reg;

   // capture divider; cleared whenever the channel is disabled
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         for (int i = 0; i < 2; i++) begin
            edge_cnt_reg[i] <= 3'h0;
         end
         capture_reg <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            capture_reg[i] <= 1'b0;
            if (!chan_en[i]) begin
               edge_cnt_reg[i] <= 3'h0; // [R09]
            end else if (edge_seen[i] && dir[i] != DIR_OUTPUT) begin
               if (edge_cnt_reg[i] >= psc_last(psc[i])) begin
                  edge_cnt_reg[i] <= 3'h0;
                  capture_reg[i]  <= 1'b1; // [R10]
               end else begin
                  edge_cnt_reg[i] <= edge_cnt_reg[i] + 3'h1; // [R10]
               end
            end
         end
      end
   end

   // read side: status shows live filter and source state
   always_comb begin
      status_word                 = 32'h0000_0000;
      status_word[ST_LEVEL0_POS]  = level_reg[0];
      status_word[ST_LEVEL1_POS]  = level_reg[1];
      status_word[ST_SRC0_POS]    = src[0];
      status_word[ST_SRC1_POS]    = src[1];
      status_word[ST_PRELOAD_POS] = preload_on;
   end

   // read data one cycle after the strobe, zero elsewhere and unmapped
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_in) begin
         unique case (addr_in)
            CTRL_OFFSET:   rdata_reg <= ctrl_reg;
            CMP_OFFSET:    rdata_reg <= cmp_shadow_reg;
            STATUS_OFFSET: rdata_reg <= status_word;
            default:       rdata_reg <= 32'h0000_0000;
         endcase
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   assign rdata_out                  = rdata_reg;
   assign ch0_capture_out            = capture_reg[0];
   assign ch1_capture_out            = capture_reg[1];
   assign filtered_level_out         = level_reg;
   assign ch0_compare_value_out      = cmp_active_reg;
   assign ch0_cmp_preload_enable_out = preload_on;

   // active compare value holds between updates under preload
   preload_hold_a: assert property ( // [R01]
      @(posedge clk_sys_in) disable iff (rst_in)
      (preload_on && !update_event_in) |=>
         (cmp_active_reg == $past(cmp_active_reg)))
      else $error("active compare changed without update");
   // update copies the shadow into the active value
   preload_xfer_a: assert property ( // [R01]
      @(posedge clk_sys_in) disable iff (rst_in)
      (preload_on && update_event_in) |=>
         (cmp_active_reg == $past(cmp_shadow_reg)))
      else $error("update did not transfer shadow");
   // direction of channel 0 frozen while enabled
   dir0_lock_a: assert property ( // [R03]
      @(posedge clk_sys_in) disable iff (rst_in)
      (ctrl_wr && ch0_active_enable_in) |=>
         (ctrl_reg[1:0] == $past(ctrl_reg[1:0])))
      else $error("channel 0 direction written while active");
   // direction of channel 1 frozen while enabled
   dir1_lock_a: assert property ( // [R11]
      @(posedge clk_sys_in) disable iff (rst_in)
      (ctrl_wr && ch1_active_enable_in) |=>
         (ctrl_reg[9:8] == $past(ctrl_reg[9:8])))
      else $error("channel 1 direction written while active");
   // pair source crosses the filtered levels
   pair_source_a: assert property ( // [R04]
      @(posedge clk_sys_in) disable iff (rst_in)
      (ctrl_reg[1:0] == 2'b10) |-> (src[0] == level_reg[1]))
      else $error("channel 0 pair source wrong");
   // trigger source silent unless an internal trigger is selected
   trig_gate_a: assert property ( // [R05]
      @(posedge clk_sys_in) disable iff (rst_in)
      (ctrl_reg[1:0] == 2'b11 && trigger_source_select_in > 3'h3)
         |-> (src[0] == 1'b0))
      else $error("trigger source used without internal trigger");
   // bypass follows the synchronised pin one cycle later
   filt_bypass_a: assert property ( // [R07]
      @(posedge clk_sys_in) disable iff (rst_in)
      (ctrl_reg[7:4] == 4'h0) |=> (level_reg[0] == $past(pin_sync_reg[0])))
      else $error("bypassed filter did not follow input");
   // a differing sample never changes the valid level
   filt_hold_a: assert property ( // [R14]
      @(posedge clk_sys_in) disable iff (rst_in)
      (ctrl_reg[7:4] != 4'h0 && strobe[0] &&
       pin_sync_reg[0] != prev_samp_reg[0])
         |=> (level_reg[0] == $past(level_reg[0])))
      else $error("filter passed a single differing sample");
   // two-sample filter at kernel rate settles in two cycles
   filt_two_a: assert property ( // [R08]
      @(posedge clk_sys_in) disable iff (rst_in)
      (ctrl_reg[7:4] == 4'h1 && $past(ctrl_reg[7:4]) == 4'h1 &&
       pin_sync_reg[0] == prev_samp_reg[0] && eq_cnt_reg[0] >= 4'h1)
         |=> (level_reg[0] == $past(pin_sync_reg[0])))
      else $error("two-sample filter did not settle");
   // disabled channel keeps its edge counter clear
   psc_reset_a: assert property ( // [R09]
      @(posedge clk_sys_in) disable iff (rst_in)
      !ch0_active_enable_in |=> (edge_cnt_reg[0] == 3'h0))
      else $error("capture divider not cleared");
   // undivided capture follows each edge by one cycle
   psc_every_a: assert property ( // [R10]
      @(posedge clk_sys_in) disable iff (rst_in)
      (ch0_active_enable_in && ctrl_reg[3:2] == 2'b00 &&
       ctrl_reg[1:0] != 2'b00 && edge_seen[0]) |=> ch0_capture_out)
      else $error("capture missing on edge");
   // no capture without a preceding edge
   psc_cause_a: assert property ( // [R10]
      @(posedge clk_sys_in) disable iff (rst_in)
      ch0_capture_out |-> $past(edge_seen[0] && ch0_active_enable_in))
      else $error("capture without edge");

endmodule

`default_nettype wire

// ### hw/timer_pair_pkg.sv
// constants, field layout and decode helpers for the timer channel pair block
package timer_pair_pkg;

   // register byte offsets
   localparam logic [7:0]  CTRL_OFFSET       = 8'h18;
   localparam logic [7:0]  CMP_OFFSET        = 8'h34;
   localparam logic [7:0]  STATUS_OFFSET     = 8'h40;

   // values after reset
   localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
   localparam logic [31:0] CMP_RESET         = 32'h0000_0000;

   // field positions inside the mode control word
   localparam int          CH0_MS_POS        = 0;
   localparam int          CH0_PSC_POS       = 2;
   localparam int          CH0_PRELOAD_POS   = 3;
   localparam int          CH0_FILT_POS      = 4;
   localparam int          CH1_MS_POS        = 8;
   localparam int          CH1_PSC_POS       = 10;
   localparam int          CH1_FILT_POS      = 12;
   localparam int          CTRL_USED_W       = 16;

   // status word bit positions
   localparam int          ST_LEVEL0_POS     = 0;
   localparam int          ST_LEVEL1_POS     = 1;
   localparam int          ST_SRC0_POS       = 2;
   localparam int          ST_SRC1_POS       = 3;
   localparam int          ST_PRELOAD_POS    = 4;

   // highest trigger source code that names an internal trigger input
   localparam logic [2:0]  TRIG_INTERNAL_LAST = 3'h3;

   // kernel clock cycles per dead-time clock cycle
   localparam logic [3:0]  DTS_DIV_CYCLES    = 4'h2;

   // channel direction and capture source choice
   typedef enum logic [1:0] {
      DIR_OUTPUT  = 2'b00,
      DIR_IN_OWN  = 2'b01,
      DIR_IN_PAIR = 2'b10,
      DIR_IN_TRIG = 2'b11
   } dir_t;

   // equal samples needed for a filter code, zero for bypass
   function automatic logic [3:0] filt_times(input logic [3:0] code);
      logic [3:0] t;
      t = 4'h0;
      unique case (code)
         4'h0: t = 4'h0;
         4'h1: t = 4'h2;
         4'h2: t = 4'h4;
         4'h3, 4'h5, 4'h7, 4'h9, 4'hC, 4'hF: t = 4'h8;
         4'h4, 4'h6, 4'h8, 4'hB, 4'hE: t = 4'h6;
         4'hA, 4'hD: t = 4'h5;
      endcase
      return t;
   endfunction

   // sample rate: 0 is kernel clock, k is dead-time clock over 2**k
   function automatic logic [2:0] filt_rate(input logic [3:0] code);
      logic [2:0] r;
      r = 3'h0;
      unique case (code)
         4'h0, 4'h1, 4'h2, 4'h3: r = 3'h0;
         4'h4, 4'h5: r = 3'h1;
         4'h6, 4'h7: r = 3'h2;
         4'h8, 4'h9: r = 3'h3;
         4'hA, 4'hB, 4'hC: r = 3'h4;
         4'hD, 4'hE, 4'hF: r = 3'h5;
      endcase
      return r;
   endfunction

endpackage

// ### bench/test_timer_channel_pair_mode_control.sv
// self-checking bench for the timer channel pair mode control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   err_total++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module test_timer_channel_pair_mode_control;
   import timer_pair_pkg::*;

   localparam int TMO = 80000;

   logic        clk_sys_in;
   logic        rst_in;
   logic [7:0]  addr_in;
   logic [31:0] wdata_in;
   logic        wr_in;
   logic        rd_in;
   logic [31:0] rdata_out;
   logic        ch0_pin_in;
   logic        ch1_pin_in;
   logic        trig_in;
   logic [2:0]  tsel_in;
   logic        en0;
   logic        en1;
   logic        upd;
   logic        cap0_o;
   logic        cap1_o;
   logic [1:0]  lvl_o;
   logic [31:0] cmp_o;
   logic        pre_o;
   int          err_total;
   int          total_checks;
   int          cyc;
   int          n_cap0;
   int          n_cap1;
   logic [31:0] ctrl_m;
   logic [31:0] shadow_m;
   logic [31:0] active_m;
   logic [31:0] d;
   logic [31:0] r;
   logic [1:0]  pv;
   int          b0;
   // equal-sample counts and sample-rate exponents per filter code
   int          nt[16] = '{0, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
   int          kr[16] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 4, 5, 5, 5};

   timer_channel_pair_mode_control i_dut (
      .clk_sys_in                 (clk_sys_in),
      .rst_in                     (rst_in),
      .addr_in                    (addr_in),
      .wdata_in                   (wdata_in),
      .wr_in                      (wr_in),
      .rd_in                      (rd_in),
      .rdata_out                  (rdata_out),
      .ch0_pin_in                 (ch0_pin_in),
      .ch1_pin_in                 (ch1_pin_in),
      .internal_trigger_line_in   (trig_in),
      .trigger_source_select_in   (tsel_in),
      .ch0_active_enable_in       (en0),
      .ch1_active_enable_in       (en1),
      .update_event_in            (upd),
      .ch0_capture_out            (cap0_o),
      .ch1_capture_out            (cap1_o),
      .filtered_level_out         (lvl_o),
      .ch0_compare_value_out      (cmp_o),
      .ch0_cmp_preload_enable_out (pre_o)
   );

   // kernel clock, 5 ns period
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   // verdict and end of run
   task automatic wrap_up();
      if (err_total == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // capture pulse counters and the hang guard
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cap0_o === 1'b1) n_cap0 <= n_cap0 + 1;
      if (cap1_o === 1'b1) n_cap1 <= n_cap1 + 1;
      if (cyc == TMO) begin
         err_total++;
         wrap_up();
      end
   end

   // compare preload is live only while channel 0 is an output
   function automatic logic pre_m();
      return ctrl_m[3] && ctrl_m[1:0] == 2'b00;
   endfunction

   // one-cycle write; the model mirrors the locked direction fields
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
      if (a == CTRL_OFFSET) begin
         ctrl_m = {16'h0000, v[15:10], en1 ? ctrl_m[9:8] : v[9:8],
                   v[7:2], en0 ? ctrl_m[1:0] : v[1:0]};
      end
      if (a == CMP_OFFSET) begin
         shadow_m = v;
         if (!pre_m()) active_m = v;
      end
   endtask

   // one-cycle read; data stands only in the following cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 v = rdata_out;
   endtask

   task automatic upd_pulse();
      @(posedge clk_sys_in);
      upd <= 1'b1;
      @(posedge clk_sys_in);
      upd <= 1'b0;
      if (pre_m()) active_m = shadow_m;
   endtask

   task automatic cmp_chk();
      @(posedge clk_sys_in);
      #1 `CHK("compare", active_m, cmp_o)
   endtask

   // source 0 and 1 are the pins, 2 the trigger line
   task automatic set_src(input int s, input logic v);
      @(posedge clk_sys_in);
      if (s == 0) ch0_pin_in <= v;
      else if (s == 1) ch1_pin_in <= v;
      else trig_in <= v;
   endtask

   task automatic pulses(input int s, input int n);
      repeat (n) begin
         set_src(s, 1'b1);
         repeat (4) @(posedge clk_sys_in);
         set_src(s, 1'b0);
         repeat (4) @(posedge clk_sys_in);
      end
      repeat (8) @(posedge clk_sys_in);
      #1;
   endtask

   // configure with channels idle, enable both, count captures
   task automatic cap_case(input logic [31:0] c, input int s, input int n,
                           input int e0, input int e1);
      int c0;
      int c1;
      @(posedge clk_sys_in);
      en0 <= 1'b0;
      en1 <= 1'b0;
      wr(CTRL_OFFSET, c);
      @(posedge clk_sys_in);
      en0 <= 1'b1;
      en1 <= 1'b1;
      @(posedge clk_sys_in);
      #1 c0 = n_cap0;
      c1 = n_cap1;
      pulses(s, n);
      `CHK("cap0", e0, n_cap0 - c0)
      `CHK("cap1", e1, n_cap1 - c1)
   endtask

   // a short glitch must not pass, a held level must pass in time
   task automatic filt(input int ch, input int code);
      int n;
      int p;
      int t;
      int lo;
      int hi;
      logic v;
      n = (code == 0) ? 1 : nt[code];
      p = (kr[code] == 0) ? 1 : int'(DTS_DIV_CYCLES) << kr[code];
      lo = (n - 1) * p + 1;
      hi = (n + 1) * p + 4;
      v = pv[ch];
      wr(CTRL_OFFSET, 32'(code) << (ch == 1 ? 12 : 4));
      if (n >= 4) begin
         set_src(ch, ~v);
         repeat ((n - 2) * p) @(posedge clk_sys_in);
         set_src(ch, v);
         repeat (hi) @(posedge clk_sys_in);
         #1 `CHK("glitch", v, lvl_o[ch])
      end
      set_src(ch, ~v);
      pv[ch] = ~v;
      t = 0;
      while (lvl_o[ch] !== ~v && t < 700) begin
         @(posedge clk_sys_in);
         t++;
      end
      `CHK("latency", 1'b1, (t >= lo && t <= hi))
      repeat (4) @(posedge clk_sys_in);
   endtask

   initial begin
      {addr_in, wdata_in, wr_in, rd_in, ch0_pin_in, ch1_pin_in} = '0;
      {trig_in, tsel_in, en0, en1, upd} = '0;
      {err_total, total_checks, cyc, n_cap0, n_cap1} = '0;
      {ctrl_m, shadow_m, active_m, pv} = '0;
      rst_in = 1'b1;
      void'($urandom(32'hdb62693a));
      repeat (4) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      rd(CTRL_OFFSET, d);
      `CHK("ctrl reset", CTRL_RESET, d)
      `CHK("cmp reset", CMP_RESET, cmp_o)
      // field storage, unused upper half, locked direction fields
      r = $urandom;
      wr(CTRL_OFFSET, r);
      rd(CTRL_OFFSET, d);
      `CHK("ctrl", ctrl_m, d)
      @(posedge clk_sys_in);
      en0 <= 1'b1;
      wr(CTRL_OFFSET, ~r);
      rd(CTRL_OFFSET, d);
      `CHK("ctrl lock0", ctrl_m, d)
      @(posedge clk_sys_in);
      en0 <= 1'b0;
      en1 <= 1'b1;
      wr(CTRL_OFFSET, r);
      rd(CTRL_OFFSET, d);
      `CHK("ctrl lock1", ctrl_m, d)
      @(posedge clk_sys_in);
      en1 <= 1'b0;
      wr(8'h20, $urandom);
      rd(8'h20, d);
      `CHK("unmapped", 32'h0000_0000, d)
      rd(CTRL_OFFSET, d);
      `CHK("ctrl kept", ctrl_m, d)
      // compare value with and without the shadow copy
      repeat (2) begin
         wr(CTRL_OFFSET, 32'h0000_0000);
         wr(CMP_OFFSET, $urandom);
         cmp_chk();
         // software turns the shadow on before relying on it
         wr(CTRL_OFFSET, 32'h0000_0008);
         #1 `CHK("preload", 1'b1, pre_o)
         wr(CMP_OFFSET, $urandom);
         cmp_chk();
         rd(CMP_OFFSET, d);
         `CHK("shadow", shadow_m, d)
         upd_pulse();
         cmp_chk();
         wr(CTRL_OFFSET, 32'h0000_0009);
         #1 `CHK("preload in", 1'b0, pre_o)
         wr(CMP_OFFSET, $urandom);
         cmp_chk();
      end
      // every divider code on both channels, own pin source
      for (int k = 0; k < 4; k++) begin
         r = 32'h0101 | (k << 2) | (k << 10);
         cap_case(r, 0, 8, 8 >> k, 0);
         cap_case(r, 1, 8, 0, 8 >> k);
      end
      cap_case(32'h0002, 1, 3, 3, 0);
      cap_case(32'h0200, 0, 3, 0, 3);
      @(posedge clk_sys_in);
      tsel_in <= TRIG_INTERNAL_LAST;
      cap_case(32'h0003, 2, 3, 3, 0);
      @(posedge clk_sys_in);
      tsel_in <= TRIG_INTERNAL_LAST + 3'h1;
      cap_case(32'h0003, 2, 3, 0, 0);
      // disabling the channel drops the partial edge count
      cap_case(32'h000D, 0, 6, 0, 0);
      @(posedge clk_sys_in);
      en0 <= 1'b0;
      @(posedge clk_sys_in);
      en0 <= 1'b1;
      @(posedge clk_sys_in);
      #1 b0 = n_cap0;
      pulses(0, 4);
      `CHK("cap cleared", 0, n_cap0 - b0)
      @(posedge clk_sys_in);
      en0 <= 1'b0;
      en1 <= 1'b0;
      // every filter code on both channels
      for (int ch = 0; ch < 2; ch++) begin
         for (int c = 0; c < 16; c++) begin
            filt(ch, c);
         end
      end
      wr(CTRL_OFFSET, 32'h0000_0008);
      rd(STATUS_OFFSET, d);
      `CHK("status", {1'b1, 2'b00, pv}, {d[4:0]})
      wrap_up();
   end
endmodule
`default_nettype wire
